// ==== common/dbg_params.svh ====
`ifndef DBG_PARAMS_SVH
`define DBG_PARAMS_SVH
// Status/control bit positions
`define SC_PERMIT_BIT 7
`define SC_ACTIVE_BIT 6
`define SC_BKPT_EN_BIT 5
`define SC_FTS_BIT 4
`define SC_DEBUG_CLOCK_SELECT_BIT 3
`define SC_WS_BIT 2
`define SC_WSF_BIT 1
`define SC_DVF_BIT 0
`define SC_RW_MASK 8'hb8
`define SC_RESET 8'h00
`define FORCE_RESET_BIT 0
`define FORCE_RESET_READ 8'h00
`define BKPT_RESET 16'h0000
// Cycles the MCU reset request is held
`define FORCE_RESET_CYCLES 4'h8
`endif

// ==== common/dbg_pkg.sv ====
package dbg_pkg;
    // Serial command codes carried from the serial front end
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_BACKGROUND = 3'h1,
        CMD_READ_STATUS = 3'h2,
        CMD_WRITE_CONTROL = 3'h3,
        CMD_READ_BREAKPOINT_CMD = 3'h4,
        CMD_WRITE_BREAKPOINT_CMD = 3'h5,
        CMD_MEM_ACCESS = 3'h6,
        CMD_WRITE_FORCE_RESET = 3'h7
    } dbg_cmd_t;

    typedef struct packed {
        logic valid;
        dbg_cmd_t cmd;
        logic [15:0] data;
    } dbg_req_t;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [15:0] data;
    } dbg_rsp_t;

    typedef struct packed {
        logic [15:0] addr;
        logic fetch;
        logic queue_end;
        logic boundary;
    } cpu_bus_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_LOWPWR = 3'b010,
        ST_HALT = 3'b100
    } core_state_t;
endpackage

// ==== verilog/bkpt_match.sv ====
`timescale 1ns/100ps
`include "dbg_params.svh"
module bkpt_match
    import dbg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic force_sel,
    input wire logic [15:0] bkpt_addr,
    input wire cpu_bus_t cpu,
    output logic halt_req
);
    logic hit;
    logic tag_q;
    logic force_q;

    assign hit = enable && (cpu.addr == bkpt_addr);

    // Force request waits for the next instruction boundary
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            force_q <= 1'b0;
        end else if (clk_en) begin
            if (!enable || cpu.boundary) begin
                force_q <= 1'b0;
            end
            if (hit && force_sel) begin
                force_q <= 1'b1;
            end
        end
    end

    // Tag follows the fetched opcode; one queue slot is modelled
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tag_q <= 1'b0;
        end else if (clk_en) begin
            if (!enable || cpu.queue_end) begin
                tag_q <= 1'b0;
            end
            if (cpu.fetch) begin
                tag_q <= hit && !force_sel;
            end
        end
    end

    assign halt_req = (force_q && cpu.boundary)
        || (tag_q && cpu.queue_end);
endmodule

// ==== verilog/debug_breakpoint_reset_ctrl.sv ====
`timescale 1ns/100ps
`include "dbg_params.svh"
module debug_breakpoint_reset_ctrl
    import dbg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire dbg_req_t req,
    output dbg_rsp_t rsp,
    input wire cpu_bus_t cpu,
    input wire logic cpu_lowpower,
    input wire logic cpu_resume,
    input wire logic user_force_reset_wr,
    input wire logic [7:0] user_wdata,
    output logic [7:0] user_rdata,
    output logic halt_req,
    output logic wake_req,
    output logic debug_active_flag,
    output logic debug_clock_select,
    output logic mcu_reset_req
);
    core_state_t state_q;
    logic [7:0] ctrl_q;
    logic [15:0] bkpt_q;
    logic ws_latch_q;
    logic wsf_q;
    logic [3:0] rst_cnt_q;
    logic bkpt_halt;
    logic needs_core;
    logic refuse;
    logic wait_fail;
    logic wr_ctrl;
    logic wr_bkpt;
    logic wr_force;
    logic bg_cmd;
    logic mcu_reset_q;
    logic [7:0] status;
    logic [15:0] rd_d;
    dbg_rsp_t rsp_q;

    bkpt_match u_bkpt (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .enable(ctrl_q[`SC_BKPT_EN_BIT]),
        .force_sel(ctrl_q[`SC_FTS_BIT]),
        .bkpt_addr(bkpt_q),
        .cpu(cpu),
        .halt_req(bkpt_halt)
    );

    // Command strobes; each acts only on an enabled edge
    assign wr_ctrl = req.valid && (req.cmd == CMD_WRITE_CONTROL);
    assign wr_bkpt = req.valid && (req.cmd == CMD_WRITE_BREAKPOINT_CMD);
    assign wr_force = req.valid && (req.cmd == CMD_WRITE_FORCE_RESET);
    assign bg_cmd = req.valid && (req.cmd == CMD_BACKGROUND);

    // Commands that act on the halted core
    assign needs_core = req.valid && (req.cmd == CMD_MEM_ACCESS);
    // A running core owns memory, so the access is refused there too
    assign refuse = needs_core && (state_q != ST_HALT);
    // Only a clash with wait or stop counts as a failure
    assign wait_fail = needs_core
        && (cpu_lowpower || (state_q == ST_LOWPWR));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_RUN;
        end else if (clk_en) begin
            case (state_q)
                ST_RUN: begin
                    if (bkpt_halt && ctrl_q[`SC_PERMIT_BIT]) begin
                        state_q <= ST_HALT;
                    end else if (cpu_lowpower) begin
                        state_q <= ST_LOWPWR;
                    end
                end
                ST_LOWPWR: begin
                    if (req.valid && req.cmd == CMD_BACKGROUND
                        && ctrl_q[`SC_PERMIT_BIT]) begin
                        state_q <= ST_HALT;
                    end else if (!cpu_lowpower) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (cpu_resume) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Gated by the clock enable so a frozen cycle raises no request
    assign wake_req = clk_en && (state_q == ST_LOWPWR) && bg_cmd
        && ctrl_q[`SC_PERMIT_BIT];
    // Only a running core can be stopped by the breakpoint
    assign halt_req = clk_en && bkpt_halt && ctrl_q[`SC_PERMIT_BIT]
        && (state_q == ST_RUN);
    assign debug_active_flag = (state_q == ST_HALT);

    // Remembers that halt was entered from wait or stop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ws_latch_q <= 1'b0;
        end else if (clk_en) begin
            if (wake_req) begin
                ws_latch_q <= 1'b1;
            end else if (state_q != ST_HALT) begin
                ws_latch_q <= 1'b0;
            end
        end
    end

    // Set wins over clear by a control write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wsf_q <= 1'b0;
        end else if (clk_en) begin
            if (wait_fail) begin
                wsf_q <= 1'b1;
            end else if (wr_ctrl) begin
                wsf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `SC_RESET;
        end else if (clk_en && wr_ctrl) begin
            ctrl_q <= req.data[7:0] & `SC_RW_MASK;
        end
    end

    // Reached only by the serial commands, never by the CPU's map
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bkpt_q <= `BKPT_RESET;
        end else if (clk_en && wr_bkpt) begin
            bkpt_q <= req.data;
        end
    end

    assign debug_clock_select = ctrl_q[`SC_DEBUG_CLOCK_SELECT_BIT];

    always_comb begin
        status = ctrl_q;
        status[`SC_ACTIVE_BIT] = debug_active_flag;
        status[`SC_WS_BIT] = (state_q == ST_LOWPWR) || ws_latch_q;
        status[`SC_WSF_BIT] = wsf_q;
        status[`SC_DVF_BIT] = 1'b0;
    end

    always_comb begin
        rd_d = 16'h0000;
        case (req.cmd)
            CMD_READ_STATUS: rd_d = {8'h00, status};
            CMD_READ_BREAKPOINT_CMD: rd_d = bkpt_q;
            default: rd_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rsp_q <= '0;
        end else if (clk_en) begin
            rsp_q.valid <= req.valid;
            rsp_q.refused <= refuse;
            rsp_q.data <= refuse ? 16'h0000 : rd_d;
        end
    end

    assign rsp = rsp_q;

    // Force reset pulse; user path never reaches it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rst_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (wr_force && req.data[`FORCE_RESET_BIT]) begin
                rst_cnt_q <= `FORCE_RESET_CYCLES;
            end else if (rst_cnt_q != 4'h0) begin
                rst_cnt_q <= rst_cnt_q - 4'h1;
            end
        end
    end

    // Registered so the reset request cannot glitch on counter edges
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mcu_reset_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_force && req.data[`FORCE_RESET_BIT]) begin
                mcu_reset_q <= 1'b1;
            end else if (rst_cnt_q == 4'h1) begin
                mcu_reset_q <= 1'b0;
            end
        end
    end

    assign mcu_reset_req = mcu_reset_q;
    // User write data and strobe deliberately unused
    assign user_rdata = `FORCE_RESET_READ;
endmodule

// ==== verification/dbg_host.sv ====
`timescale 1ns/100ps
module dbg_host
    import dbg_pkg::*;
(
    input wire logic clk,
    input wire dbg_rsp_t rsp,
    output dbg_req_t req
);
    initial req = '0;
    // One pulse per command; the answer is taken in its single valid cycle
    task automatic send(input dbg_cmd_t c, input logic [15:0] d,
            output dbg_rsp_t r);
        @(negedge clk);
        req = '{1'b1, c, d};
        @(negedge clk);
        req = '0;
        r = rsp;
    endtask
endmodule

// ==== verification/dbg_ctrl_assertions.sv ====
`timescale 1ns/100ps
module dbg_ctrl_checker
    import dbg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire dbg_req_t req,
    input wire dbg_rsp_t rsp,
    input wire cpu_bus_t cpu,
    input wire logic cpu_lowpower,
    input wire logic [7:0] user_rdata,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic debug_active_flag,
    input wire logic debug_clock_select,
    input wire logic mcu_reset_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_answer_next: assert property (clk_en && req.valid
        |=> rsp.valid)
        else $error("no answer");
    a_answer_cause: assert property (rsp.valid && $past(clk_en)
        |-> $past(req.valid))
        else $error("stray answer");
    a_lowpwr_refuse: assert property (clk_en && req.valid
        && cpu_lowpower && req.cmd == CMD_MEM_ACCESS |=> rsp.refused)
        else $error("access not refused");
    a_wake_cause: assert property (wake_req |-> req.valid
        && req.cmd == CMD_BACKGROUND && cpu_lowpower)
        else $error("stray wake");
    a_halt_cause: assert property (halt_req |-> cpu.boundary
        || cpu.queue_end)
        else $error("halt off boundary");
    a_clksel_write: assert property ($changed(debug_clock_select)
        |-> $past(req.valid && req.cmd == CMD_WRITE_CONTROL))
        else $error("clock select moved");
    a_user_zero: assert property (user_rdata == 8'h00)
        else $error("force reset read nonzero");
    a_reset_cause: assert property ($rose(mcu_reset_req) |->
        $past(req.valid && req.cmd == CMD_WRITE_FORCE_RESET && req.data[0]))
        else $error("reset without serial write");
    a_reset_hold: assert property ($rose(mcu_reset_req) |->
        mcu_reset_req[*8] ##1 !mcu_reset_req)
        else $error("reset length");
    a_halt_enter: assert property (halt_req |=> debug_active_flag)
        else $error("breakpoint did not halt");
    a_wake_enter: assert property (wake_req |=> debug_active_flag)
        else $error("background did not halt");
    c_wake: cover property (wake_req);
    c_halt: cover property (halt_req);
    c_reset: cover property ($rose(mcu_reset_req));
endmodule

bind debug_breakpoint_reset_ctrl dbg_ctrl_checker u_chk (.clk(clk),
    .reset(reset), .req(req), .rsp(rsp), .cpu(cpu),
    .cpu_lowpower(cpu_lowpower), .user_rdata(user_rdata),
    .halt_req(halt_req), .wake_req(wake_req),
    .clk_en(clk_en), .debug_active_flag(debug_active_flag),
    .debug_clock_select(debug_clock_select),
    .mcu_reset_req(mcu_reset_req));

// ==== verification/debug_breakpoint_reset_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`include "dbg_params.svh"
module debug_breakpoint_reset_ctrl_tb_top;
    import dbg_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic lowpwr = 1'b0;
    logic resume = 1'b0;
    logic user_wr = 1'b0;
    cpu_bus_t cpu = '0;
    dbg_req_t req;
    dbg_rsp_t rsp, r;
    logic [7:0] user_rdata;
    logic halt_req, clk_sel, mcu_rst;
    logic clk_en = 1'b1;
    logic act;
    logic [15:0] a;
    int err_count = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    dbg_host host (.clk(clk), .rsp(rsp), .req(req));
    debug_breakpoint_reset_ctrl DUT (.clk(clk), .reset(reset),
        .clk_en(clk_en), .req(req), .rsp(rsp), .cpu(cpu),
        .cpu_lowpower(lowpwr), .cpu_resume(resume),
        .user_force_reset_wr(user_wr), .user_wdata(8'hff),
        .user_rdata(user_rdata), .halt_req(halt_req), .wake_req(),
        .debug_active_flag(act), .debug_clock_select(clk_sel),
        .mcu_reset_req(mcu_rst));
    function automatic logic [15:0] st(input logic [7:0] c,
            input logic [2:0] f);
        return {8'h00, c & `SC_RW_MASK | {1'b0, f[2], 3'b0, f[1:0], 1'b0}};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic stat(input logic [7:0] c, input logic [2:0] f);
        host.send(CMD_READ_STATUS, 16'h0000, r);
        chk({8'h00, r.data[7:0]}, st(c, f));
    endtask
    // Match cycle, then one cycle of the given fetch/queue/boundary flags
    task automatic hit(input logic [2:0] f, input logic e);
        @(negedge clk);
        cpu = {a, 3'b100};
        @(negedge clk);
        cpu = {~a, f};
        #1 chk(16'(halt_req), 16'(e));
        @(negedge clk);
        chk(16'(act), 16'(e));
        cpu = '0;
        resume = 1'b1;
        @(negedge clk);
        resume = 1'b0;
    endtask
    task automatic print_verdict;
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hee0c9099));
        repeat (5) @(negedge clk);
        reset = 1'b0;
        stat(8'h00, 3'b000);
        chk(16'(clk_sel), 16'h0000);
        // A request during a frozen cycle must be neither taken nor answered
        @(negedge clk);
        clk_en = 1'b0;
        host.send(CMD_WRITE_CONTROL, 16'h0008, r);
        chk(16'(r.valid), 16'h0000);
        chk(16'(clk_sel), 16'h0000);
        clk_en = 1'b1;
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            host.send(CMD_WRITE_BREAKPOINT_CMD, a, r);
            host.send(CMD_READ_BREAKPOINT_CMD, 16'h0000, r);
            chk(r.data, a);
        end
        host.send(CMD_WRITE_CONTROL, 16'h00b8, r);
        chk(16'(clk_sel), 16'h0001);
        hit(3'b001, 1'b1);
        host.send(CMD_WRITE_CONTROL, 16'h00a0, r);
        hit(3'b001, 1'b0);
        hit(3'b010, 1'b1);
        host.send(CMD_WRITE_CONTROL, 16'h0090, r);
        hit(3'b001, 1'b0);
        host.send(CMD_MEM_ACCESS, 16'h0000, r);
        chk(16'(r.refused), 16'h0001);
        stat(8'h90, 3'b000);
        lowpwr = 1'b1;
        host.send(CMD_MEM_ACCESS, 16'h0000, r);
        chk(16'(r.refused), 16'h0001);
        stat(8'h90, 3'b011);
        host.send(CMD_BACKGROUND, 16'h0000, r);
        chk(16'(act), 16'h0001);
        lowpwr = 1'b0;
        stat(8'h90, 3'b111);
        host.send(CMD_MEM_ACCESS, 16'h0000, r);
        chk(16'(r.refused), 16'h0000);
        host.send(CMD_WRITE_CONTROL, 16'h0090, r);
        @(negedge clk);
        resume = 1'b1;
        @(negedge clk);
        resume = 1'b0;
        stat(8'h90, 3'b000);
        chk(16'(act), 16'h0000);
        user_wr = 1'b1;
        @(negedge clk);
        user_wr = 1'b0;
        chk(16'(user_rdata), 16'h0000);
        chk(16'(mcu_rst), 16'h0000);
        host.send(CMD_WRITE_FORCE_RESET, 16'h00fe, r);
        chk(16'(mcu_rst), 16'h0000);
        host.send(CMD_WRITE_FORCE_RESET, 16'h0001, r);
        chk(16'(mcu_rst), 16'h0001);
        repeat (10) @(negedge clk);
        chk(16'(mcu_rst), 16'h0000);
        print_verdict();
    end
endmodule
